/* logic/dstc_pkg.sv */
/*
  Shared constants for the self-test command logic: command field layout,
  command identifiers, format codes, response bit positions and reset values.
  Assumes nothing of its surroundings; every user names items as dstc_pkg::name.
*/
package dstc_pkg;

  // Command word layout: data byte, address nibble, command nibble.
  localparam int CMD_W = 16;
  localparam int CMD_ID_LSB = 0;
  localparam int ADDR_LSB = 4;
  localparam int DATA_LSB = 8;
  localparam int NIB_W = 4;

  // Command identifiers decoded or refused by this block.
  localparam logic [3:0] CMD_ID_ENABLE = 4'hD;
  localparam logic [3:0] CMD_ID_DISABLE = 4'hC;
  localparam logic [3:0] CMD_ID_UNUSED14 = 4'hE;
  localparam logic [3:0] CMD_ID_REV_INIT = 4'hF;
  localparam logic [3:0] ADDR_GLOBAL = 4'h0;

  // Command format codes presented with each received command.
  localparam logic [1:0] FMT_STD_LONG = 2'h0;
  localparam logic [1:0] FMT_STD_SHORT = 2'h1;
  localparam logic [1:0] FMT_ENH_LONG = 2'h2;
  localparam logic [1:0] FMT_ENH_SHORT = 2'h3;

  // Status byte bit positions, shared by the short and the long response.
  localparam int RSP_SHORT_W = 15;
  localparam int RSP_LONG_W = 16;
  localparam int RSP_OTP_BIT = 7;
  localparam int RSP_HOLD_BIT = 6;
  localparam int RSP_CHECK_BIT = 5;
  localparam int RSP_SWITCH_BIT = 4;
  localparam int RSP_TRAIT_MSB = 3;
  localparam int RSP_TRAIT_LSB = 2;
  localparam int RSP_ERR_BIT = 1;
  localparam int RSP_ZERO_LSB = 0;
  localparam int RSP_LONG_ADDR_LSB = 12;
  localparam int RSP_STATUS_MSB = 7;

  // Values after reset.
  localparam logic RST_SELF_CHECK = 1'b0;
  localparam logic RST_LOCKOUT = 1'b0;
  localparam logic [1:0] RST_SYNC = 2'h0;

  // Lockout tracking states.
  typedef enum logic [1:0] {LK_IDLE, LK_ONE_DISABLE, LK_LOCKED} dstc_lock_t;

endpackage

/* logic/dstc_rsp_build.sv */
/*
  Combinational builder of the short and long self-test response words.
  Assumes the core registers the words before they leave the block.
*/
`timescale 1ns/1ps
module dstc_rsp_build (
  // Status in, words out.
  dstc_rsp_if.build rsp
);
  logic [dstc_pkg::RSP_STATUS_MSB:0] status;

  // One status byte serves both words, so the two can never disagree.
  always_comb begin
    status = '0;
    status[dstc_pkg::RSP_OTP_BIT] = rsp.otp_en;
    status[dstc_pkg::RSP_HOLD_BIT] = rsp.hold_low;
    status[dstc_pkg::RSP_CHECK_BIT] = rsp.check_act;
    status[dstc_pkg::RSP_SWITCH_BIT] = rsp.bus_sw;
    status[dstc_pkg::RSP_TRAIT_MSB:dstc_pkg::RSP_TRAIT_LSB] = rsp.trait;
    status[dstc_pkg::RSP_ERR_BIT] = rsp.int_err;
    status[dstc_pkg::RSP_ZERO_LSB] = 1'b0;
  end

  // Upper bits are zero in the short word; the long word carries the address.
  assign rsp.short_word = {7'h00, status};
  assign rsp.long_word = {rsp.addr, 4'h0, status};
endmodule // dstc_rsp_build

/* logic/dstc_rsp_if.sv */
/*
  Carrier between the command core and the response builder: the status
  inputs of one response and the two response words built from them.
  Assumes both ends sit on the same clock; the builder is combinational.
*/
`timescale 1ns/1ps
interface dstc_rsp_if;
  logic otp_en;
  logic hold_low;
  logic check_act;
  logic bus_sw;
  logic [1:0] trait;
  logic int_err;
  logic [3:0] addr;
  logic [dstc_pkg::RSP_SHORT_W-1:0] short_word;
  logic [dstc_pkg::RSP_LONG_W-1:0] long_word;

  // The core supplies status and takes words; the builder does the reverse.
  modport core (output otp_en, hold_low, check_act, bus_sw, trait, int_err, addr,
                input short_word, long_word);
  modport build (input otp_en, hold_low, check_act, bus_sw, trait, int_err, addr,
                 output short_word, long_word);
endinterface

/* logic/dstc_sync2.sv */
/*
  Two flip-flop level synchroniser for a pin that is not on the core clock.
  Assumes a synchronous active-high reset on the destination clock.
*/
`timescale 1ns/1ps
module dstc_sync2 (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic srst_i,
  // Asynchronous level in, synchronised level out.
  input wire logic async_i,
  output logic sync_o
);
  logic [1:0] stage_q;

  // Only the second stage is read, so a metastable first stage never leaks.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stage_q <= dstc_pkg::RST_SYNC;
    end else begin
      stage_q <= {stage_q[0], async_i};
    end
  end

  assign sync_o = stage_q[1];
endmodule // dstc_sync2

/* logic/dstc_top.sv */
/*
  Self-test command logic of a bus sensor node: decodes Enable and Disable
  Self-Test, refuses unimplemented and misaddressed commands, tracks the
  lockout armed by two Disable commands and builds the status responses.
  Assumes a frame decoder on the same clock presents each received command as
  a one-cycle strobe with its word, format and CRC verdict; the hold-capacitor
  comparator is asynchronous and is synchronised here.
*/
// Overview of operation
// - Short response: status in bits 7-1, rest zero
// - Long response: address on top, zeros, status byte
// - Error flag set when internal error detected
// - Trait bits copied from device config one
// - Bus switch bit reflects and controls switch
// - Self-check flag shows circuitry active
// - Hold-capacitor flag set below threshold
// - OTP flag shows programming enabled
// - Two back-to-back Disables arm lockout
// - Lockout holds until UV, Clear, hold-capacitor low or reset
// - Enable accepted in four formats, enhanced configurable
// - Command data byte only feeds CRC
// - Enable to global address is ignored
// - Enable starts stimulus until Disable arrives
// - Locked Enable: no activation, flag returns zero
// - Enable is command identifier 1101
// - Address mismatch means command ignored
// - Identifier 1110 ignored in every format
// - Identifier 1111 ignored in every format
// - Commands from downstream pin are ignored
// - Disable is identifier 1100, stops self-check
`timescale 1ns/1ps
module dstc_top (
  // Clock and reset.
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  // Received command strobe and its attributes.
  input wire logic CMD_VALID_I,
  input wire logic [dstc_pkg::CMD_W-1:0] CMD_WORD_I,
  input wire logic [1:0] CMD_FORMAT_I,
  input wire logic CMD_CRC_OK_I,
  input wire logic CMD_FROM_DOWNSTREAM_I,
  // Format control settings for the enhanced formats.
  input wire logic ENH_LONG_EN_I,
  input wire logic ENH_SHORT_EN_I,
  // Device configuration and status sources.
  input wire logic [3:0] DEV_ADDR_I,
  input wire logic [1:0] DEVICE_TRAIT_PAIR_I,
  input wire logic OTP_PROGRAM_ENABLE_FLAG_I,
  input wire logic BUS_SWITCH_STATE_I,
  input wire logic INT_ERROR_I,
  input wire logic HOLD_CAPACITOR_VOLTAGE_LOW_I,
  // Lockout release events, one-cycle pulses.
  input wire logic CLEAR_CMD_I,
  input wire logic REG_UV_RESET_I,
  input wire logic FRAME_TIMEOUT_RESET_I,
  // Self-check control and status.
  output logic SELF_CHECK_ACTIVE_O,
  output logic SELF_CHECK_LOCKOUT_O,
  output logic BUS_SWITCH_CLOSE_O,
  output logic CMD_IGNORED_O,
  // Response words.
  output logic RSP_VALID_O,
  output logic RSP_LONG_SEL_O,
  output logic [dstc_pkg::RSP_SHORT_W-1:0] RSP_SHORT_O,
  output logic [dstc_pkg::RSP_LONG_W-1:0] RSP_LONG_O
);

  // True when an address names this device and is not the global address.
  function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] own);
    return (a == own) && (a != dstc_pkg::ADDR_GLOBAL);
  endfunction

  // True for identifiers this device never implements.
  function automatic logic id_unimpl(input logic [3:0] id);
    return (id == dstc_pkg::CMD_ID_UNUSED14) || (id == dstc_pkg::CMD_ID_REV_INIT);
  endfunction

  logic hold_low;
  logic [3:0] cmd_id;
  logic [3:0] cmd_addr;
  logic fmt_ok;
  logic cmd_seen;
  logic acc_any;
  logic acc_en;
  logic acc_dis;
  logic arm_lock;
  logic release_lock;
  logic reset_release;
  logic locked;
  logic chk_d;
  logic chk_q;
  logic lock_q;
  logic sw_q;
  logic ign_q;
  logic rsp_valid_q;
  logic rsp_long_q;
  logic [dstc_pkg::RSP_SHORT_W-1:0] rsp_short_q;
  logic [dstc_pkg::RSP_LONG_W-1:0] rsp_long_w_q;
  dstc_pkg::dstc_lock_t lk_d;
  dstc_pkg::dstc_lock_t lk_q;

  dstc_rsp_if rsp ();

  // The comparator output is asynchronous to the core clock.
  dstc_sync2 u_hold_sync (
    .clk_i(CORE_CLK_I),
    .srst_i(SRST_I),
    .async_i(HOLD_CAPACITOR_VOLTAGE_LOW_I),
    .sync_o(hold_low)
  );

  dstc_rsp_build u_build (
    .rsp(rsp.build)
  );

  // The data byte is deliberately never decoded; the frame decoder folds it
  // into the CRC check that arrives here as CMD_CRC_OK_I.
  assign cmd_id = CMD_WORD_I[dstc_pkg::CMD_ID_LSB +: dstc_pkg::NIB_W];
  assign cmd_addr = CMD_WORD_I[dstc_pkg::ADDR_LSB +: dstc_pkg::NIB_W];

  // Standard formats are always taken; enhanced ones only once configured.
  always_comb begin
    case (CMD_FORMAT_I)
      dstc_pkg::FMT_STD_LONG: fmt_ok = 1'b1;
      dstc_pkg::FMT_STD_SHORT: fmt_ok = 1'b1;
      dstc_pkg::FMT_ENH_LONG: fmt_ok = ENH_LONG_EN_I;
      dstc_pkg::FMT_ENH_SHORT: fmt_ok = ENH_SHORT_EN_I;
      default: fmt_ok = 1'b0;
    endcase
  end

  // A command counts only from the upstream input with a good CRC.
  assign cmd_seen = CMD_VALID_I && !CMD_FROM_DOWNSTREAM_I && CMD_CRC_OK_I && fmt_ok;

  // Unimplemented identifiers and foreign or global addresses are dropped.
  assign acc_any = cmd_seen && !id_unimpl(cmd_id)
                   && addr_hit(cmd_addr, DEV_ADDR_I);
  assign acc_en = acc_any && (cmd_id == dstc_pkg::CMD_ID_ENABLE);
  assign acc_dis = acc_any && (cmd_id == dstc_pkg::CMD_ID_DISABLE);

  // Events that end a lockout; the two reset sources also stop self-check.
  assign reset_release = REG_UV_RESET_I || FRAME_TIMEOUT_RESET_I;
  assign release_lock = hold_low || CLEAR_CMD_I || reset_release;
  assign locked = (lk_q == dstc_pkg::LK_LOCKED);
  assign arm_lock = acc_dis && (lk_q == dstc_pkg::LK_ONE_DISABLE);

  // Lockout tracker. Arming wins over a release in the same cycle so that a
  // second Disable is never lost.
  always_comb begin
    lk_d = lk_q;
    case (lk_q)
      dstc_pkg::LK_IDLE: begin
        if (acc_dis) begin
          lk_d = dstc_pkg::LK_ONE_DISABLE;
        end
      end
      dstc_pkg::LK_ONE_DISABLE: begin
        if (acc_dis) begin
          lk_d = dstc_pkg::LK_LOCKED;
        end else if (acc_any || release_lock) begin
          lk_d = dstc_pkg::LK_IDLE;
        end
      end
      dstc_pkg::LK_LOCKED: begin
        if (release_lock) begin
          lk_d = dstc_pkg::LK_IDLE;
        end
      end
      default: lk_d = dstc_pkg::LK_IDLE;
    endcase
  end

  // Lockout state register.
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      lk_q <= dstc_pkg::LK_IDLE;
    end else begin
      lk_q <= lk_d;
    end
  end

  // Lockout flag, registered so that the output comes straight from a flop.
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      lock_q <= dstc_pkg::RST_LOCKOUT;
    end else begin
      lock_q <= (lk_d == dstc_pkg::LK_LOCKED);
    end
  end

  // Self-check stimulus: on with an Enable, off with a Disable or a reset
  // source. A locked Enable leaves it off.
  always_comb begin
    chk_d = chk_q;
    if (reset_release || acc_dis) begin
      chk_d = 1'b0;
    end else if (acc_en && !locked) begin
      chk_d = 1'b1;
    end else if (locked) begin
      chk_d = 1'b0;
    end
  end

  // Self-check state register.
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      chk_q <= dstc_pkg::RST_SELF_CHECK;
    end else begin
      chk_q <= chk_d;
    end
  end

  // Bus switch command follows its state bit one cycle later.
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      sw_q <= 1'b0;
    end else begin
      sw_q <= BUS_SWITCH_STATE_I;
    end
  end

  // Pulse for any command this block refused, downstream ones included.
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      ign_q <= 1'b0;
    end else begin
      ign_q <= CMD_VALID_I && !acc_any;
    end
  end

  // Status for the builder; the self-check bit is the value after this
  // command, so a locked Enable reports it cleared.
  assign rsp.otp_en = OTP_PROGRAM_ENABLE_FLAG_I;
  assign rsp.hold_low = hold_low;
  assign rsp.check_act = chk_d;
  assign rsp.bus_sw = BUS_SWITCH_STATE_I;
  assign rsp.trait = DEVICE_TRAIT_PAIR_I;
  assign rsp.int_err = INT_ERROR_I;
  assign rsp.addr = DEV_ADDR_I;

  // Response capture for accepted Enable and Disable commands; the words
  // hold until the next response so a slow encoder may read them late.
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      rsp_valid_q <= 1'b0;
      rsp_long_q <= 1'b0;
      rsp_short_q <= '0;
    end else begin
      rsp_valid_q <= acc_en || acc_dis;
      if (acc_en || acc_dis) begin
        rsp_long_q <= (CMD_FORMAT_I == dstc_pkg::FMT_STD_LONG)
                      || (CMD_FORMAT_I == dstc_pkg::FMT_ENH_LONG);
        rsp_short_q <= rsp.short_word;
      end
    end
  end

  // Long word register, kept apart so it resets with its own process.
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      rsp_long_w_q <= '0;
    end else if (acc_en || acc_dis) begin
      rsp_long_w_q <= rsp.long_word;
    end
  end

  assign SELF_CHECK_ACTIVE_O = chk_q;
  assign SELF_CHECK_LOCKOUT_O = lock_q;
  assign BUS_SWITCH_CLOSE_O = sw_q;
  assign CMD_IGNORED_O = ign_q;
  assign RSP_VALID_O = rsp_valid_q;
  assign RSP_LONG_SEL_O = rsp_long_q;
  assign RSP_SHORT_O = rsp_short_q;
  assign RSP_LONG_O = rsp_long_w_q;

  // Checks on the block's own outputs and decode.
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);

  AST_SHORT_LAYOUT:
    assert property (RSP_VALID_O |-> (RSP_SHORT_O[14:8] == 7'h00) && !RSP_SHORT_O[0])
    else $error("Short response has a nonzero fixed bit.");

  AST_LONG_LAYOUT:
    assert property ((acc_en || acc_dis) |=> RSP_LONG_O[15:12] == $past(DEV_ADDR_I)
                     && RSP_LONG_O[11:8] == 4'h0 && RSP_LONG_O[7:0] == RSP_SHORT_O[7:0])
    else $error("Long response address or status byte is wrong.");

  AST_ERR_BIT:
    assert property ((acc_en || acc_dis) |=> RSP_SHORT_O[1] == $past(INT_ERROR_I))
    else $error("Error bit does not follow the internal error.");

  AST_TRAIT_BITS:
    assert property ((acc_en || acc_dis) |=> RSP_SHORT_O[3:2] == $past(DEVICE_TRAIT_PAIR_I))
    else $error("Trait bits do not follow the configuration.");

  AST_LOCK_ARM:
    assert property ((acc_dis && !(locked && release_lock))
                     ##1 (acc_dis && !(locked && release_lock)) |=> SELF_CHECK_LOCKOUT_O)
    else $error("Two Disables in a row did not arm lockout.");

  AST_LOCK_HOLDS_OFF:
    assert property (SELF_CHECK_LOCKOUT_O |-> !SELF_CHECK_ACTIVE_O)
    else $error("Self-check active while locked out.");

  AST_LOCK_RELEASE:
    assert property (locked && release_lock && !acc_dis |=> !SELF_CHECK_LOCKOUT_O)
    else $error("Lockout survived a release event.");

  AST_ENABLE_STARTS:
    assert property (acc_en && !locked && !reset_release |=> SELF_CHECK_ACTIVE_O
                     && RSP_VALID_O && RSP_SHORT_O[5])
    else $error("Accepted Enable did not start self-check.");

  AST_LOCKED_ENABLE:
    assert property (acc_en && locked |=> !SELF_CHECK_ACTIVE_O && !RSP_SHORT_O[5])
    else $error("Locked Enable activated self-check.");

  AST_GLOBAL_DROPPED:
    assert property (CMD_VALID_I && cmd_addr == 4'h0 |-> !acc_any ##1 CMD_IGNORED_O)
    else $error("Command to the global address was accepted.");

  AST_UNIMPL_DROPPED:
    assert property (CMD_VALID_I && id_unimpl(cmd_id) |=> !RSP_VALID_O
                     && $stable(SELF_CHECK_ACTIVE_O) || $past(reset_release))
    else $error("Unimplemented identifier had an effect.");

  AST_DOWNSTREAM_DROPPED:
    assert property (CMD_VALID_I && CMD_FROM_DOWNSTREAM_I |-> !acc_any)
    else $error("Command from the downstream pin was accepted.");

  AST_DISABLE_STOPS:
    assert property (acc_dis |=> !SELF_CHECK_ACTIVE_O && RSP_VALID_O && !RSP_SHORT_O[5])
    else $error("Disable did not stop self-check.");

  AST_COUNT_RESTART:
    assert property ((acc_dis && lk_q == dstc_pkg::LK_IDLE) ##1 (acc_any && !acc_dis)
                     |=> lk_q == dstc_pkg::LK_IDLE)
    else $error("Intervening command did not restart the Disable count.");

  COV_ENABLE: cover property (acc_en && !locked ##1 SELF_CHECK_ACTIVE_O);
  COV_LOCKOUT: cover property (acc_dis ##1 acc_dis ##1 SELF_CHECK_LOCKOUT_O);
  COV_LOCKED_ENABLE: cover property (acc_en && locked);
  COV_RELEASE: cover property (SELF_CHECK_LOCKOUT_O ##1 !SELF_CHECK_LOCKOUT_O);

endmodule // dstc_top

/* verif/dstc_master_model.sv */
/*
  Bus master model: presents received commands to the self-test logic, one
  command per clock while the strobe is high.
  Assumes the bench calls its tasks from one thread, in order.
*/
`timescale 1ns/1ps
module dstc_master_model (
  // Clock.
  input wire logic clk_i,
  // Command as handed over by the frame decoder.
  output logic cmd_valid_o,
  output logic [15:0] cmd_word_o,
  output logic [1:0] cmd_format_o,
  output logic cmd_crc_ok_o,
  output logic cmd_down_o
);
  // Idle values at time zero.
  initial begin
    cmd_valid_o = 1'b0;
    cmd_word_o = 16'hA5A5;
    cmd_format_o = 2'h0;
    cmd_crc_ok_o = 1'b0;
    cmd_down_o = 1'b0;
  end

  // One command per call; back to back calls keep the strobe high.
  task automatic send(input logic [3:0] addr, input logic [3:0] id, input logic [1:0] fmt,
                      input logic crc_ok, input logic down);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_word_o <= {8'($urandom), addr, id};
    cmd_format_o <= fmt;
    cmd_crc_ok_o <= crc_ok;
    cmd_down_o <= down;
  endtask

  // Strobe low; the word flips every cycle so stale data never looks held.
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_i);
      cmd_valid_o <= 1'b0;
      cmd_word_o <= ~cmd_word_o;
      cmd_crc_ok_o <= ~cmd_crc_ok_o;
    end
  endtask
endmodule // dstc_master_model

/* verif/dstc_top_tb.sv */
/*
  Self-checking bench of the self-test command logic: a cycle model predicts
  every output, compared at each falling edge.
  Assumes the master model drives all command inputs.
*/
`timescale 1ns/1ps
module dstc_top_tb;
  logic clk, srst, valid, crc_ok, down, enh_l, enh_s, otp, bsw, ierr, hold, clr, uv, fto;
  logic [15:0] word;
  logic [1:0] fmt, trait;
  logic [3:0] dev;
  logic chk_o, lk_o, sw_o, ign_o, rv_o, ls_o;
  logic [14:0] sh_o;
  logic [15:0] lo_o;
  logic e_chk, e_lk, e_cnt, e_ign, e_rv, e_ls, e_sw, h1, h2, a, rel, arm;
  logic [7:0] sb;
  logic [14:0] e_sh;
  logic [15:0] e_lo;
  int err_count, comparisons, cycles;

  dstc_master_model i_dstc_master_model (.clk_i(clk), .cmd_valid_o(valid), .cmd_word_o(word),
    .cmd_format_o(fmt), .cmd_crc_ok_o(crc_ok), .cmd_down_o(down));

  dstc_top i_dstc_top (.CORE_CLK_I(clk), .SRST_I(srst), .CMD_VALID_I(valid),
    .CMD_WORD_I(word), .CMD_FORMAT_I(fmt), .CMD_CRC_OK_I(crc_ok),
    .CMD_FROM_DOWNSTREAM_I(down), .ENH_LONG_EN_I(enh_l), .ENH_SHORT_EN_I(enh_s),
    .DEV_ADDR_I(dev), .DEVICE_TRAIT_PAIR_I(trait), .OTP_PROGRAM_ENABLE_FLAG_I(otp),
    .BUS_SWITCH_STATE_I(bsw), .INT_ERROR_I(ierr), .HOLD_CAPACITOR_VOLTAGE_LOW_I(hold),
    .CLEAR_CMD_I(clr), .REG_UV_RESET_I(uv), .FRAME_TIMEOUT_RESET_I(fto),
    .SELF_CHECK_ACTIVE_O(chk_o), .SELF_CHECK_LOCKOUT_O(lk_o), .BUS_SWITCH_CLOSE_O(sw_o),
    .CMD_IGNORED_O(ign_o), .RSP_VALID_O(rv_o), .RSP_LONG_SEL_O(ls_o),
    .RSP_SHORT_O(sh_o), .RSP_LONG_O(lo_o));

  // Clock at 200 MHz.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A command counts only when every acceptance condition holds.
  function automatic logic accepted(input logic [15:0] w, input logic [1:0] f);
    return crc_ok && !down && w[3:0] != 4'hE && w[3:0] != 4'hF && w[7:4] == dev &&
      w[7:4] != 4'h0 && (f < 2'h2 || (f == 2'h2 ? enh_l : enh_s));
  endfunction

  // Reference model, one update per edge from the inputs the design also samples.
  always @(posedge clk) begin
    if (srst) begin
      {e_chk, e_lk, e_cnt, e_ign, e_rv, e_ls, e_sw, h1, h2} = 9'h000;
      e_sh = 15'h0000;
      e_lo = 16'h0000;
    end else begin
      a = valid && accepted(word, fmt);
      e_ign = valid && !a;
      e_rv = a && (word[3:0] == 4'hC || word[3:0] == 4'hD);
      rel = clr | uv | fto | h2;
      // Arming beats a release; a release or another accepted command restarts the count.
      arm = a && word[3:0] == 4'hC && e_cnt && !e_lk;
      if (a && word[3:0] == 4'hD)
        e_chk = (e_chk | !e_lk) & !(uv | fto);
      else if ((a && word[3:0] == 4'hC) || uv || fto)
        e_chk = 1'b0;
      e_cnt = !e_lk && !arm && (e_cnt ? !(a || rel) : (a && word[3:0] == 4'hC));
      e_lk = arm || (e_lk && !rel);
      if (e_rv) begin
        sb = {otp, h2, e_chk, bsw, trait, ierr, 1'b0};
        e_sh = {7'h00, sb};
        e_lo = {dev, 4'h0, sb};
        e_ls = !fmt[0];
      end
      e_sw = bsw;
      h2 = h1;
      h1 = hold;
    end
  end

  // Every output is compared once a cycle where it is settled.
  always @(negedge clk) begin
    check("active", 16'(chk_o), 16'(e_chk));
    check("lockout", 16'(lk_o), 16'(e_lk));
    check("switch", 16'(sw_o), 16'(e_sw));
    check("ignored", 16'(ign_o), 16'(e_ign));
    check("rsp_valid", 16'(rv_o), 16'(e_rv));
    check("long_sel", 16'(ls_o), 16'(e_ls));
    check("short", 16'(sh_o), 16'(e_sh));
    check("long", lo_o, e_lo);
  end

  // Hang guard, well above the roughly 1400 cycles the sequence needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      conclude();
    end
  end

  // One release event; the strobe is dropped first so no command is repeated.
  task automatic pulse(input int k);
    i_dstc_master_model.idle(1);
    @(posedge clk);
    case (k)
      0: clr <= 1'b1;
      1: uv <= 1'b1;
      2: fto <= 1'b1;
      default: hold <= 1'b1;
    endcase
    @(posedge clk);
    {clr, uv, fto, hold} <= 4'h0;
    i_dstc_master_model.idle(3);
  endtask

  // New status levels, settled before the next command.
  task automatic cfg();
    i_dstc_master_model.idle(2);
    dev <= ($urandom % 8 == 0) ? 4'h0 : 4'($urandom % 15 + 1);
    otp <= 1'($urandom);
    bsw <= 1'($urandom);
    ierr <= 1'($urandom);
    trait <= 2'($urandom);
    enh_l <= ($urandom % 4 != 0);
    enh_s <= ($urandom % 4 != 0);
    i_dstc_master_model.idle(3);
  endtask

  // Random command biased to this device and to the two self-test ids.
  task automatic rnd();
    logic [3:0] ad, id;
    ad = ($urandom % 5 < 3) ? dev : 4'($urandom);
    id = ($urandom % 3 == 0) ? 4'($urandom) : (($urandom % 2) ? 4'hC : 4'hD);
    i_dstc_master_model.send(ad, id, 2'($urandom), $urandom % 10 != 0, $urandom % 10 == 0);
  endtask

  // Main sequence: directed corners, then random traffic.
  initial begin
    void'($urandom(32'h53215275));
    {srst, enh_l, enh_s, otp, bsw} = 5'h1F;
    {ierr, hold, clr, uv, fto} = 5'h00;
    trait = 2'h2;
    dev = 4'h5;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    i_dstc_master_model.send(4'h5, 4'hD, 2'h0, 1'b1, 1'b0);
    i_dstc_master_model.idle(2);
    i_dstc_master_model.send(4'h0, 4'hD, 2'h1, 1'b1, 1'b0);
    i_dstc_master_model.send(4'h5, 4'hC, 2'h1, 1'b1, 1'b0);
    i_dstc_master_model.send(4'h5, 4'hC, 2'h0, 1'b1, 1'b0);
    i_dstc_master_model.send(4'h5, 4'hD, 2'h2, 1'b1, 1'b0);
    for (int k = 0; k < 4; k++) begin
      pulse(k);
      i_dstc_master_model.send(4'h5, 4'hD, 2'h3, 1'b1, 1'b0);
      i_dstc_master_model.send(4'h5, 4'hC, 2'h0, 1'b1, 1'b0);
      i_dstc_master_model.send(4'h5, 4'hC, 2'h1, 1'b1, 1'b0);
    end
    pulse(0);
    i_dstc_master_model.send(4'h5, 4'hC, 2'h0, 1'b1, 1'b0);
    i_dstc_master_model.send(4'h5, 4'h3, 2'h0, 1'b1, 1'b0);
    i_dstc_master_model.send(4'h5, 4'hC, 2'h0, 1'b1, 1'b0);
    for (int f = 0; f < 4; f++) begin
      i_dstc_master_model.send(4'h5, 4'hE, 2'(f), 1'b1, 1'b0);
      i_dstc_master_model.send(4'h5, 4'hF, 2'(f), 1'b1, 1'b0);
      i_dstc_master_model.send(4'h5, 4'hD, 2'(f), 1'b0, 1'b0);
      i_dstc_master_model.send(4'h5, 4'hD, 2'(f), 1'b1, 1'b1);
      i_dstc_master_model.send(4'h6, 4'hD, 2'(f), 1'b1, 1'b0);
    end
    i_dstc_master_model.idle(2);
    {enh_l, enh_s} <= 2'h0;
    i_dstc_master_model.send(4'h5, 4'hD, 2'h2, 1'b1, 1'b0);
    i_dstc_master_model.send(4'h5, 4'hD, 2'h3, 1'b1, 1'b0);
    repeat (800) begin
      if ($urandom % 40 == 0)
        cfg();
      if ($urandom % 60 == 0)
        pulse($urandom % 3);
      rnd();
      if ($urandom % 3 == 0)
        i_dstc_master_model.idle(1);
    end
    i_dstc_master_model.idle(4);
    conclude();
  end
endmodule // dstc_top_tb
